// >>> sic_pkg.sv
// Purpose : Shared constants for the subsystem interrupt controller
// Assumes : 32-bit APB register bus, 16-bit flag and mask layout
// Notes   : All offsets are byte addresses

// ****************************************
// Package
// ****************************************
package sic_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_MASK    = 8'h00;
  localparam logic [7:0] OFS_FLAGS   = 8'h04;
  localparam logic [7:0] OFS_BANKSW  = 8'h08;
  localparam logic [7:0] OFS_DMASEL  = 8'h0c;
  localparam logic [7:0] OFS_HOSTCTL = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_TRAP    = 8'h18;

  // Flag and mask bit positions
  localparam int BIT_EXT0  = 0;
  localparam int BIT_EXT1  = 1;
  localparam int BIT_TIMER = 3;
  localparam int BIT_SP0RX = 4;
  localparam int BIT_SP0TX = 5;
  localparam int BIT_SEL6  = 6;
  localparam int BIT_SEL7  = 7;
  localparam int BIT_HOST  = 9;
  localparam int BIT_SEL10 = 10;
  localparam int BIT_SEL11 = 11;
  localparam int BIT_DMA4  = 12;
  localparam int BIT_DMA5  = 13;
  localparam int BIT_PEER  = 14;

  // Implemented bits; 15, 8 and 2 are reserved
  localparam logic [15:0] VALID_BITS = 16'h7efb;

  // Reset values
  localparam logic [15:0] RST_MASK   = 16'h0000;
  localparam logic [15:0] RST_FLAGS  = 16'h0000;
  localparam logic [3:0]  RST_DMASEL = 4'h0;

  // Vector and priority encoding
  localparam logic [6:0] VEC_RESET  = 7'h00;
  localparam logic [4:0] PRIO_RESET = 5'h01;
  localparam logic [6:0] VEC_BASE   = 7'h40;
  localparam logic [4:0] PRIO_BASE  = 5'h03;

  // Status register fields
  localparam int ST_IRQ_POS  = 15;
  localparam int ST_PRIO_POS = 8;

  // Synchroniser depth for pins
  localparam int SYNC_STAGES = 3;

endpackage

// >>> sic_req_if.sv
// Purpose : Request and answer bundle between flag logic and priority picker
// Assumes : Single clock domain
// Notes   : Purely combinational carrier

`timescale 1ns/10ps

// ****************************************
// Interface
// ****************************************
interface sic_req_if;
  logic [15:0] pending;
  logic        rst_pend;
  logic        valid;
  logic        is_rst;
  logic [3:0]  idx;
  logic [6:0]  vec;
  logic [4:0]  prio;

  modport ctrl (output pending, output rst_pend,
                input valid, input is_rst, input idx, input vec, input prio);
  modport pick (input pending, input rst_pend,
                output valid, output is_rst, output idx, output vec, output prio);
endinterface

// >>> sic_prio.sv
// Purpose : Picks the pending request with the smallest priority number
// Assumes : Pending bits already gated by mask and reserved bits
// Notes   : Reset request always outranks every flag

`timescale 1ns/10ps

// ****************************************
// Priority picker
// ****************************************
module sic_prio (
  sic_req_if.pick req
);

  function automatic logic [6:0] vec_of(input logic [3:0] i);
    vec_of = sic_pkg::VEC_BASE + {1'b0, i, 2'b00};
  endfunction

  always_comb begin
    req.valid  = 1'b0;
    req.is_rst = 1'b0;
    req.idx    = 4'h0;
    req.vec    = sic_pkg::VEC_RESET;
    req.prio   = sic_pkg::PRIO_RESET;
    // Downward scan so the lowest bit, the smallest number, wins
    for (int i = 15; i >= 0; i--) begin
      if (req.pending[i]) begin
        req.valid = 1'b1;
        req.idx   = 4'(i);
      end
    end
    if (req.valid) begin
      req.vec  = vec_of(req.idx);
      req.prio = sic_pkg::PRIO_BASE + {1'b0, req.idx};
    end
    if (req.rst_pend) begin
      req.valid  = 1'b1;
      req.is_rst = 1'b1;
      req.idx    = 4'h0;
      req.vec    = sic_pkg::VEC_RESET;
      req.prio   = sic_pkg::PRIO_RESET;
    end
  end

endmodule

// >>> sic_top.sv
// Purpose : Per-subsystem interrupt flag, mask and vector logic on APB
// Assumes : Peripheral requests are one-cycle pulses on clk_i
// Notes   : External pins and peer request cross in through three flops

`timescale 1ns/10ps

module sic_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // APB slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // External pins, active low
  input  wire logic              ext_irq_zero_n_i,
  input  wire logic              ext_irq_one_n_i,
  // On-chip request pulses
  input  wire logic              timer_irq_i,
  input  wire logic              sp0_rx_irq_i,
  input  wire logic              sp0_tx_irq_i,
  input  wire logic              sp1_rx_irq_i,
  input  wire logic              sp1_tx_irq_i,
  input  wire logic              sp2_rx_irq_i,
  input  wire logic              sp2_tx_irq_i,
  input  wire logic [5:0]        dma_irq_i,
  // Peer subsystem
  input  wire logic              peer_core_irq_i,
  output logic                   peer_irq_request_o,
  // Core vector port
  input  wire logic              irq_ack_i,
  output logic                   irq_o,
  output logic      [6:0]        irq_vector_o,
  output logic      [4:0]        irq_prio_o
);

  // ****************************************
  // Declarations
  // ****************************************
  sic_req_if req ();

  logic [15:0] interrupt_mask;
  logic [15:0] interrupt_flags;
  logic        peer_irq_request;
  logic [3:0]  dma_sel;
  logic [6:0]  trap_loc;
  logic        rst_pend;
  logic        irq_is_rst;
  logic [3:0]  irq_idx;

  logic [2:0]  sync1;
  logic [2:0]  sync2;
  logic [2:0]  sync3;
  logic [2:0]  stable;
  logic [2:0]  next_stable;
  logic [2:0]  rise;

  logic        acc;
  logic        wr;
  logic        hit;
  logic        host_req;
  logic [15:0] set_ev;
  logic [15:0] clr_ev;
  logic [15:0] next_flags;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a == ADDR_W'(sic_pkg::OFS_MASK))    || (a == ADDR_W'(sic_pkg::OFS_FLAGS))  ||
               (a == ADDR_W'(sic_pkg::OFS_BANKSW))  || (a == ADDR_W'(sic_pkg::OFS_DMASEL)) ||
               (a == ADDR_W'(sic_pkg::OFS_HOSTCTL)) || (a == ADDR_W'(sic_pkg::OFS_STATUS)) ||
               (a == ADDR_W'(sic_pkg::OFS_TRAP));
  endfunction

  function automatic logic is_wr(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    is_wr = wr && (a == ADDR_W'(ofs));
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Only agreeing second and third stages move the stable level
  assign next_stable = (sync2 & sync3) | (stable & (sync2 | sync3));
  assign rise        = next_stable & ~stable;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1  <= 3'h0;
      sync2  <= 3'h0;
      sync3  <= 3'h0;
      stable <= 3'h0;
    end else begin
      sync1  <= {peer_core_irq_i, ~ext_irq_one_n_i, ~ext_irq_zero_n_i};
      sync2  <= sync1;
      sync3  <= sync2;
      stable <= next_stable;
    end
  end

  // ****************************************
  // APB decode
  // ****************************************
  assign acc       = psel_i && penable_i;
  assign wr        = acc && pwrite_i;
  assign hit       = addr_hit(paddr_i);
  assign pready_o  = 1'b1;
  assign pslverr_o = acc && !hit;
  assign host_req  = is_wr(paddr_i, sic_pkg::OFS_HOSTCTL) && pwdata_i[0];

  // ****************************************
  // Flag set and clear
  // ****************************************
  always_comb begin
    set_ev                       = 16'h0000;
    set_ev[sic_pkg::BIT_EXT0]    = rise[0];
    set_ev[sic_pkg::BIT_EXT1]    = rise[1];
    set_ev[sic_pkg::BIT_TIMER]   = timer_irq_i;
    set_ev[sic_pkg::BIT_SP0RX]   = sp0_rx_irq_i;
    set_ev[sic_pkg::BIT_SP0TX]   = sp0_tx_irq_i;
    set_ev[sic_pkg::BIT_SEL6]    = dma_sel[0] ? dma_irq_i[0] : sp2_rx_irq_i;
    set_ev[sic_pkg::BIT_SEL7]    = dma_sel[1] ? dma_irq_i[1] : sp2_tx_irq_i;
    set_ev[sic_pkg::BIT_HOST]    = host_req;
    set_ev[sic_pkg::BIT_SEL10]   = dma_sel[2] ? dma_irq_i[2] : sp1_rx_irq_i;
    set_ev[sic_pkg::BIT_SEL11]   = dma_sel[3] ? dma_irq_i[3] : sp1_tx_irq_i;
    set_ev[sic_pkg::BIT_DMA4]    = dma_irq_i[4];
    set_ev[sic_pkg::BIT_DMA5]    = dma_irq_i[5];
    set_ev[sic_pkg::BIT_PEER]    = rise[2];
    clr_ev = 16'h0000;
    if (is_wr(paddr_i, sic_pkg::OFS_FLAGS)) begin
      clr_ev = pwdata_i[15:0];
    end
    if (irq_ack_i && irq_o && !irq_is_rst) begin
      clr_ev[irq_idx] = 1'b1;
    end
    // A set in the clearing cycle survives
    next_flags = ((interrupt_flags & ~clr_ev) | set_ev) & sic_pkg::VALID_BITS;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_flags <= sic_pkg::RST_FLAGS;
    end else begin
      interrupt_flags <= next_flags;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_mask   <= sic_pkg::RST_MASK;
      peer_irq_request <= 1'b0;
      dma_sel          <= sic_pkg::RST_DMASEL;
      trap_loc         <= 7'h00;
    end else begin
      if (is_wr(paddr_i, sic_pkg::OFS_MASK)) begin
        interrupt_mask <= pwdata_i[15:0] & sic_pkg::VALID_BITS;
      end
      if (is_wr(paddr_i, sic_pkg::OFS_BANKSW)) begin
        // Level stays up until software writes zero again
        peer_irq_request <= pwdata_i[0];
      end
      if (is_wr(paddr_i, sic_pkg::OFS_DMASEL)) begin
        dma_sel <= pwdata_i[3:0];
      end
      if (is_wr(paddr_i, sic_pkg::OFS_TRAP)) begin
        // Upper software numbers map to 0x04 through 0x40, the last one on the first hardware vector
        trap_loc <= pwdata_i[4] ? {1'b0, pwdata_i[3:0], 2'b00} + 7'h04
                                : sic_pkg::VEC_BASE + {1'b0, pwdata_i[3:0], 2'b00};
      end
    end
  end

  assign peer_irq_request_o = peer_irq_request;

  // ****************************************
  // Vector selection
  // ****************************************
  assign req.pending  = interrupt_flags & interrupt_mask & sic_pkg::VALID_BITS;
  assign req.rst_pend = rst_pend;

  sic_prio u_prio (
    .req (req)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_pend <= 1'b1;
    end else if (irq_ack_i && irq_o && irq_is_rst) begin
      rst_pend <= 1'b0;
    end
  end

  // Registered one cycle behind the flags to keep outputs glitch free
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o        <= 1'b0;
      irq_is_rst   <= 1'b0;
      irq_idx      <= 4'h0;
      irq_vector_o <= 7'h00;
      irq_prio_o   <= 5'h00;
    end else begin
      irq_o        <= req.valid;
      irq_is_rst   <= req.is_rst;
      irq_idx      <= req.idx;
      irq_vector_o <= req.vec;
      irq_prio_o   <= req.prio;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i) begin
      prdata_o <= 32'h0000_0000;
      case (paddr_i)
        ADDR_W'(sic_pkg::OFS_MASK):   prdata_o[15:0] <= interrupt_mask;
        ADDR_W'(sic_pkg::OFS_FLAGS):  prdata_o[15:0] <= interrupt_flags;
        ADDR_W'(sic_pkg::OFS_BANKSW): prdata_o[0]    <= peer_irq_request;
        ADDR_W'(sic_pkg::OFS_DMASEL): prdata_o[3:0]  <= dma_sel;
        ADDR_W'(sic_pkg::OFS_STATUS): begin
          prdata_o[sic_pkg::ST_IRQ_POS]                        <= irq_o;
          prdata_o[sic_pkg::ST_PRIO_POS +: 5]                  <= irq_prio_o;
          prdata_o[6:0]                                        <= irq_vector_o;
        end
        ADDR_W'(sic_pkg::OFS_TRAP):   prdata_o[6:0]  <= trap_loc;
        default:                      prdata_o       <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic [15:0] low_mask;
  assign low_mask = (16'h0001 << irq_idx) - 16'h0001;

  sequence seq_peer_rise;
    !peer_core_irq_i [*4] ##1 peer_core_irq_i [*4];
  endsequence

  sequence seq_only_pending(logic [15:0] p);
    !rst_pend && (req.pending == p);
  endsequence

  AST_EXT0_VEC: assert property (seq_only_pending(16'h0001) |=>
    irq_o && irq_vector_o == 7'h40 && irq_prio_o == 5'h03)
    else $error("External zero vector wrong");

  AST_EXT1_VEC: assert property (seq_only_pending(16'h0002) |=>
    irq_vector_o == 7'h44 && irq_prio_o == 5'h04)
    else $error("External one vector wrong");

  AST_TIMER_VEC: assert property (seq_only_pending(16'h0008) |=>
    irq_vector_o == 7'h4c && irq_prio_o == 5'h06)
    else $error("Timer vector wrong");

  AST_PEER_LATCH: assert property (seq_peer_rise |-> ##[1:4] interrupt_flags[14])
    else $error("Peer interrupt not latched");

  AST_SEL6_SOURCE: assert property (sp2_rx_irq_i && !dma_sel[0] |=> interrupt_flags[6])
    else $error("Serial source not routed to bit 6");

  AST_HOST_REQ: assert property (host_req |=> interrupt_flags[9])
    else $error("Host request not flagged");

  AST_PEER_OUT: assert property (wr && paddr_i == ADDR_W'(sic_pkg::OFS_BANKSW)
    |=> peer_irq_request_o == $past(pwdata_i[0]))
    else $error("Peer request not raised");

  AST_RESERVED: assert property (((interrupt_flags | interrupt_mask) & 16'h8104) == 16'h0000)
    else $error("Reserved bit set");

  AST_RESET_VEC: assert property ($past(rst_i) |=>
    irq_o && irq_vector_o == 7'h00 && irq_prio_o == 5'h01)
    else $error("Reset vector not first");

  AST_LOWEST_WINS: assert property (irq_o && !irq_is_rst |->
    ($past(req.pending) & low_mask) == 16'h0000 &&
    ($past(req.pending) & (16'h0001 << irq_idx)) != 16'h0000)
    else $error("Lower number request skipped");

  AST_SET_WINS: assert property (timer_irq_i && irq_ack_i && irq_o && irq_idx == 4'h3
    |=> interrupt_flags[3])
    else $error("Set lost against clear");

endmodule

// >>> sic_far_model.sv
// Purpose : Far-side model: pins, peripheral pulses and the peer subsystem
// Assumes : Pulses last one clk_i cycle, pins idle high
// Notes   : Peer request is a level, held between requests

`timescale 1ns/10ps

// ****************************************
// Far-side model
// ****************************************
module sic_far_model (
  // Clock
  input  wire logic       clk_i,
  // Pins and pulses
  output logic            ext_zero_n_o,
  output logic            ext_one_n_o,
  output logic [6:0]      per_o,
  output logic [5:0]      dma_o,
  output logic            peer_o
);
  initial begin
    ext_zero_n_o = 1'b1;
    ext_one_n_o  = 1'b1;
    per_o        = 7'h00;
    dma_o        = 6'h00;
    peer_o       = 1'b0;
  end

  // Group 0: timer, sp0 rx/tx, sp1 rx/tx, sp2 rx/tx; group 1: DMA channels
  task automatic pulse(input int grp, input int i);
    @(posedge clk_i);
    if (grp == 0) per_o[i] <= 1'b1;
    else dma_o[i] <= 1'b1;
    @(posedge clk_i);
    per_o <= 7'h00;
    dma_o <= 6'h00;
  endtask

  // Held low long enough to clear the pin synchroniser
  task automatic pin(input int n);
    @(posedge clk_i);
    if (n == 0) ext_zero_n_o <= 1'b0;
    else ext_one_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    ext_zero_n_o <= 1'b1;
    ext_one_n_o  <= 1'b1;
  endtask

  // A second request is only seen after the level has dropped
  task automatic peer_raise();
    if (peer_o === 1'b1) begin
      @(posedge clk_i);
      peer_o <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    @(posedge clk_i);
    peer_o <= 1'b1;
  endtask
endmodule

// >>> subsystem_interrupt_controller_tb_top.sv
// Purpose : Self-checking bench for the interrupt controller
// Assumes : Zero-wait APB slave, registered vector outputs
// Notes   : Every source is taken through flag, mask, vector and ack

`timescale 1ns/10ps

module subsystem_interrupt_controller_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext0_n, ext1_n, peer_in, peer_req, ack = 1'b0, irq;
  logic [6:0]  per, vec;
  logic [5:0]  dma;
  logic [4:0]  prio;
  logic [31:0] rd;
  logic        err;
  int          fails = 0, n_compared = 0, cyc = 0;
  int          bits[13] = '{0, 1, 3, 4, 5, 6, 7, 9, 10, 11, 12, 13, 14};

  always #25 clk_i = ~clk_i;

  sic_far_model far (.clk_i(clk_i), .ext_zero_n_o(ext0_n), .ext_one_n_o(ext1_n),
    .per_o(per), .dma_o(dma), .peer_o(peer_in));

  sic_top DUT (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .ext_irq_zero_n_i(ext0_n),
    .ext_irq_one_n_i(ext1_n), .timer_irq_i(per[0]), .sp0_rx_irq_i(per[1]),
    .sp0_tx_irq_i(per[2]), .sp1_rx_irq_i(per[3]), .sp1_tx_irq_i(per[4]),
    .sp2_rx_irq_i(per[5]), .sp2_tx_irq_i(per[6]), .dma_irq_i(dma),
    .peer_core_irq_i(peer_in), .peer_irq_request_o(peer_req), .irq_ack_i(ack),
    .irq_o(irq), .irq_vector_o(vec), .irq_prio_o(prio));

  // ****************************************
  // Bench tasks
  // ****************************************
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_irq();
    for (int k = 0; k < 40 && irq !== 1'b1; k++) @(negedge clk_i);
  endtask

  task automatic do_ack();
    @(posedge clk_i);
    ack <= 1'b1;
    @(posedge clk_i);
    ack <= 1'b0;
    repeat (3) @(negedge clk_i);
  endtask

  task automatic fire(input int b, input logic sel);
    if (sel && (b == 6 || b == 7)) far.pulse(1, b - 6);
    else if (sel && (b == 10 || b == 11)) far.pulse(1, b - 8);
    else begin
      case (b)
        0, 1:    far.pin(b);
        3, 4, 5: far.pulse(0, b - 3);
        6, 7:    far.pulse(0, b - 1);
        9:       apb(1'b1, sic_pkg::OFS_HOSTCTL, 32'h1);
        10, 11:  far.pulse(0, b - 7);
        12, 13:  far.pulse(1, b - 8);
        default: far.peer_raise();
      endcase
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk({16'h0, irq, 2'h0, prio, 1'b0, vec}, 32'h8100);
    do_ack();
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, sic_pkg::OFS_FLAGS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, sic_pkg::OFS_MASK, 32'hffffffff);
    apb(1'b0, sic_pkg::OFS_MASK, 32'h0);
    chk(rd, 32'h7efb);
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk({31'h0, pready}, 32'h1);
    for (int n = 29; n <= 30; n++) begin
      apb(1'b1, sic_pkg::OFS_TRAP, n);
      apb(1'b0, sic_pkg::OFS_TRAP, 32'h0);
      chk(rd, (n == 29) ? 32'h38 : 32'h3c);
    end
    apb(1'b1, sic_pkg::OFS_BANKSW, 32'h1);
    repeat (2) @(negedge clk_i);
    chk({31'h0, peer_req}, 32'h1);
    apb(1'b1, sic_pkg::OFS_BANKSW, 32'h0);
    repeat (2) @(negedge clk_i);
    chk({31'h0, peer_req}, 32'h0);
    // Unselected sources must leave the shared bits alone
    apb(1'b1, sic_pkg::OFS_MASK, 32'h0);
    for (int i = 0; i < 4; i++) far.pulse(1, i);
    apb(1'b1, sic_pkg::OFS_DMASEL, 32'hf);
    for (int i = 3; i < 7; i++) far.pulse(0, i);
    apb(1'b0, sic_pkg::OFS_FLAGS, 32'h0);
    chk(rd, 32'h0);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, sic_pkg::OFS_DMASEL, s ? 32'hf : 32'h0);
      foreach (bits[j]) begin
        apb(1'b1, sic_pkg::OFS_MASK, 32'h1 << bits[j]);
        fire(bits[j], s[0]);
        wait_irq();
        chk({25'h0, vec}, 32'h40 + 4 * bits[j]);
        chk({27'h0, prio}, bits[j] + 3);
        apb(1'b0, sic_pkg::OFS_FLAGS, 32'h0);
        chk(rd, 32'h1 << bits[j]);
        do_ack();
        chk({31'h0, irq}, 32'h0);
      end
    end
    // Masked requests wait; the smallest priority number goes first
    apb(1'b1, sic_pkg::OFS_MASK, 32'h0);
    apb(1'b1, sic_pkg::OFS_DMASEL, 32'h0);
    far.pulse(0, 0);
    far.pulse(1, 5);
    far.pulse(0, 4);
    repeat (3) @(negedge clk_i);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, sic_pkg::OFS_FLAGS, 32'h800);
    apb(1'b0, sic_pkg::OFS_FLAGS, 32'h0);
    chk(rd, 32'h2008);
    apb(1'b1, sic_pkg::OFS_MASK, 32'hffff);
    wait_irq();
    apb(1'b0, sic_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h864c);
    do_ack();
    wait_irq();
    chk({20'h0, prio, vec}, 32'h874);
    do_ack();
    // A timer pulse in the ack cycle must survive the clear
    far.pulse(0, 0);
    wait_irq();
    fork
      do_ack();
      far.pulse(0, 0);
    join
    apb(1'b0, sic_pkg::OFS_FLAGS, 32'h0);
    chk(rd, 32'h8);
    chk({31'h0, irq}, 32'h1);
    do_ack();
    apb(1'b0, sic_pkg::OFS_FLAGS, 32'h0);
    chk(rd, 32'h0);
    final_report();
  end
endmodule
